// ### rtl/vtoc_defines.vh
// Constants for the transmit command logic: offsets, fields, codes.
// Assumes inclusion by bare name from the rtl folder.
`ifndef VTOC_DEFINES_VH
`define VTOC_DEFINES_VH
// Register word offsets (byte address = 4 * index)
`define VTOC_IDX_CMD 8'hf3
`define VTOC_IDX_DATA 8'hf1
`define VTOC_IDX_ADDR 8'hf4
`define VTOC_IDX_CTRL 8'hf5
`define VTOC_IDX_STAT 8'hf6
`define VTOC_IDX_RXCNT 8'hf7
`define VTOC_RST_CMD 8'h00
`define VTOC_RST_CTRL 8'h00
// Command fields
`define VTOC_OP_LSB 0
`define VTOC_OP_MSB 2
`define VTOC_LEN_LSB 4
`define VTOC_LEN_MSB 7
// Command codes
`define VTOC_CODE_CANCEL 3'h0
`define VTOC_CODE_BRK 3'h1
`define VTOC_CODE_BODY 3'h2
`define VTOC_CODE_LAST 3'h3
`define VTOC_CODE_RSP1 3'h4
`define VTOC_CODE_RSP2 3'h5
`define VTOC_CODE_RSP3 3'h6
`define VTOC_CODE_RSP3C 3'h7
// Frame limits
`define VTOC_MAX_LEN 4'hb
`define VTOC_BODY_LIM 4'ha
// Status bit positions
`define VTOC_ST_RDY 0
`define VTOC_ST_ABT 1
`define VTOC_ST_UDF 2
`define VTOC_ST_BUSY 3
// Bit cell length and system clock period in nanoseconds
`define VTOC_BIT_NS 16'd64000
`define VTOC_CLK_NS 16'd10
`endif

// ### rtl/vtoc_shifter.v
// Serializer for one byte onto the bus output, with optional lead-in.
// Assumes a single clock; symbol timing is a plain bit cell count.
`timescale 1ns/1ps
`default_nettype none
module vtoc_shifter #(
  parameter CELL = 6400
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Load side
  input wire load,
  input wire [7:0] byte_in,
  input wire with_sof,
  // Status and pin
  output reg busy_q,
  output reg done_q,
  output reg pin_q
);
  reg [7:0] sh_q;
  reg [3:0] bits_q;
  reg [15:0] cnt_q;
  reg sof_q;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh_q <= 8'h00;
      bits_q <= 4'h0;
      cnt_q <= 16'h0000;
      sof_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (load && !busy_q) begin
        sh_q <= byte_in;
        bits_q <= 4'h8;
        sof_q <= with_sof;
        cnt_q <= CELL[15:0];
        busy_q <= 1'b1;
        pin_q <= with_sof ? 1'b1 : byte_in[7];
      end else if (busy_q) begin
        if (cnt_q != 16'h0001) begin
          cnt_q <= cnt_q - 16'h0001;
        end else begin
          cnt_q <= CELL[15:0];
          if (sof_q) begin
            sof_q <= 1'b0;
            pin_q <= sh_q[7];
          end else if (bits_q == 4'h1) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            pin_q <= 1'b0;
          end else begin
            sh_q <= {sh_q[6:0], 1'b0};
            bits_q <= bits_q - 4'h1;
            pin_q <= sh_q[6];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/vtoc_tx_command.v
// Transmit command logic: command register, checks, byte sequencing.
// Assumes receive-side status arrives as synchronous inputs on sys_clk.
`include "vtoc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module vtoc_tx_command #(
  parameter CELL = `VTOC_BIT_NS / `VTOC_CLK_NS
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Avalon-MM slave
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Receive path status
  input wire bus_idle,
  input wire arb_lost,
  input wire eod_seen,
  input wire crc_ok,
  input wire rx_in_response,
  input wire [3:0] rx_count,
  // Bus pin
  output reg bus_output_pin
);
  localparam S_IDLE = 3'h0;
  localparam S_SEND = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_CRC = 3'h3;
  localparam S_EOD = 3'h4;
  reg [7:0] transmit_command_q;
  reg [7:0] outgoing_byte_reg_q;
  reg [7:0] phys_addr_q;
  reg length_limit_off_q;
  reg command_ready_flag_q;
  reg request_aborted_flag_q;
  reg underflow_flag_q;
  reg pend_q;
  reg [2:0] state_q;
  reg [2:0] run_code_q;
  reg [7:0] crc_q;
  reg inv_crc_q;
  reg skip_next_q;
  reg ack_q;
  reg [2:0] eod_sync_q;
  reg sh_load;
  reg [7:0] sh_byte;
  reg sh_sof;
  wire sh_busy;
  wire sh_done;
  wire sh_pin;
  wire [7:0] reg_idx = avs_address[9:2];
  // Write lands only at the edge where the master sees waitrequest low
  wire bus_wr = avs_write && ack_q && avs_byteenable[0];
  wire cmd_wr = bus_wr && reg_idx == `VTOC_IDX_CMD;
  wire [2:0] wr_code = avs_writedata[`VTOC_OP_MSB:`VTOC_OP_LSB];
  wire [3:0] wr_len = avs_writedata[`VTOC_LEN_MSB:`VTOC_LEN_LSB];
  wire [2:0] q_code = transmit_command_q[`VTOC_OP_MSB:`VTOC_OP_LSB];
  wire [3:0] q_len = transmit_command_q[`VTOC_LEN_MSB:`VTOC_LEN_LSB];
  wire eod_rise = eod_sync_q[1] && !eod_sync_q[2];

  // Decode helpers used in several places
  function is_resp;
    input [2:0] c;
    begin
      is_resp = c[2];
    end
  endfunction
  function uses_crc;
    input [2:0] c;
    begin
      uses_crc = (c == `VTOC_CODE_LAST) || (c == `VTOC_CODE_RSP3C);
    end
  endfunction
  function [7:0] crc_step;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] r;
    begin
      r = c;
      for (i = 7; i >= 0; i = i - 1) begin
        r = (r[7] ^ d[i]) ? {r[6:0], 1'b0} ^ 8'h1d : {r[6:0], 1'b0};
      end
      crc_step = r;
    end
  endfunction

  // Up-front validity of a command write
  reg wr_abort;
  reg wr_udf;
  always @* begin
    wr_abort = 1'b0;
    wr_udf = 1'b0;
    case (wr_code)
      `VTOC_CODE_BODY, `VTOC_CODE_LAST: begin
        if (state_q != S_IDLE && run_code_q == `VTOC_CODE_RSP3) begin
          wr_abort = 1'b1;
          wr_udf = 1'b1;
        end else if (!length_limit_off_q && state_q != S_IDLE &&
                     wr_code == `VTOC_CODE_BODY &&
                     rx_count == `VTOC_BODY_LIM) begin
          wr_abort = 1'b1;
          wr_udf = 1'b1;
        end else if (!length_limit_off_q && state_q != S_IDLE &&
                     rx_count > `VTOC_BODY_LIM) begin
          wr_abort = 1'b1;
          wr_udf = 1'b1;
        end
      end
      `VTOC_CODE_RSP1, `VTOC_CODE_RSP2, `VTOC_CODE_RSP3,
      `VTOC_CODE_RSP3C: begin
        if (!length_limit_off_q && wr_len > `VTOC_MAX_LEN) begin
          wr_abort = 1'b1;
        end else if (rx_in_response) begin
          wr_abort = 1'b1;
        end else if (state_q != S_IDLE) begin
          wr_abort = 1'b1;
          wr_udf = run_code_q == `VTOC_CODE_BODY ||
                   run_code_q == `VTOC_CODE_RSP3;
        end
      end
      default: begin
        wr_abort = 1'b0;
      end
    endcase
  end

  // Response gate checked at the end-of-data symbol
  wire len_ok = q_len == 4'h0 || q_len == rx_count;
  wire cnt_ok = length_limit_off_q || rx_count <= `VTOC_MAX_LEN;
  wire resp_go = len_ok && cnt_ok && crc_ok;

  vtoc_shifter #(.CELL(CELL)) u_shift (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(sh_load),
    .byte_in(sh_byte),
    .with_sof(sh_sof),
    .busy_q(sh_busy),
    .done_q(sh_done),
    .pin_q(sh_pin)
  );

  // Shifter load selection
  always @* begin
    sh_load = 1'b0;
    sh_sof = 1'b0;
    sh_byte = outgoing_byte_reg_q;
    if (state_q == S_CRC && !sh_busy) begin
      sh_load = 1'b1;
      sh_byte = inv_crc_q ? ~crc_q : crc_q;
    end else if (pend_q && !sh_busy && !arb_lost &&
                 (state_q == S_IDLE || state_q == S_SEND)) begin
      if (!is_resp(q_code)) begin
        // After an underflow the next body waits for a fresh frame
        sh_load = !skip_next_q || bus_idle;
        sh_sof = bus_idle;
      end else if (eod_rise && resp_go) begin
        sh_load = 1'b1;
        if (q_code == `VTOC_CODE_RSP1 || q_code == `VTOC_CODE_RSP2) begin
          sh_byte = phys_addr_q;
        end
      end
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      transmit_command_q <= `VTOC_RST_CMD;
      outgoing_byte_reg_q <= 8'h00;
      phys_addr_q <= 8'h00;
      length_limit_off_q <= 1'b0;
      command_ready_flag_q <= 1'b1;
      request_aborted_flag_q <= 1'b0;
      underflow_flag_q <= 1'b0;
      pend_q <= 1'b0;
      state_q <= S_IDLE;
      run_code_q <= 3'h0;
      crc_q <= 8'hff;
      inv_crc_q <= 1'b0;
      skip_next_q <= 1'b0;
      ack_q <= 1'b0;
      eod_sync_q <= 3'h0;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      bus_output_pin <= 1'b0;
    end else begin
      eod_sync_q <= {eod_sync_q[1:0], eod_seen};
      bus_output_pin <= sh_pin;
      // One wait state, then acknowledge
      ack_q <= (avs_read || avs_write) && !ack_q;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
      if (avs_read && !ack_q) begin
        case (reg_idx)
          `VTOC_IDX_CMD: avs_readdata <= {24'h0, transmit_command_q};
          `VTOC_IDX_DATA: avs_readdata <= {24'h0, outgoing_byte_reg_q};
          `VTOC_IDX_ADDR: avs_readdata <= {24'h0, phys_addr_q};
          `VTOC_IDX_CTRL: avs_readdata <= {31'h0, length_limit_off_q};
          `VTOC_IDX_STAT: avs_readdata <= {28'h0, state_q != S_IDLE,
            underflow_flag_q, request_aborted_flag_q, command_ready_flag_q};
          `VTOC_IDX_RXCNT: avs_readdata <= {28'h0, rx_count};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
      if (bus_wr && reg_idx == `VTOC_IDX_DATA) begin
        outgoing_byte_reg_q <= avs_writedata[7:0];
      end
      if (bus_wr && reg_idx == `VTOC_IDX_ADDR) begin
        phys_addr_q <= avs_writedata[7:0];
      end
      if (bus_wr && reg_idx == `VTOC_IDX_CTRL) begin
        length_limit_off_q <= avs_writedata[0];
      end
      // Write-zero clears; a same-cycle hardware set wins below
      if (bus_wr && reg_idx == `VTOC_IDX_STAT) begin
        if (!avs_writedata[`VTOC_ST_ABT]) request_aborted_flag_q <= 1'b0;
        if (!avs_writedata[`VTOC_ST_UDF]) underflow_flag_q <= 1'b0;
      end
      if (sh_load) begin
        command_ready_flag_q <= 1'b1;
        pend_q <= 1'b0;
        crc_q <= crc_step(crc_q, sh_byte);
        if (state_q != S_CRC) begin
          run_code_q <= q_code;
          state_q <= uses_crc(q_code) ? S_CRC : S_SEND;
        end else begin
          state_q <= S_EOD;
        end
        if (sh_sof) begin
          crc_q <= crc_step(8'hff, sh_byte);
          skip_next_q <= 1'b0;
        end
      end else if (state_q == S_CRC && !sh_busy) begin
        state_q <= S_EOD;
      end else if (state_q == S_SEND && sh_done && !pend_q) begin
        state_q <= S_WAIT;
      end else if (state_q == S_WAIT) begin
        state_q <= S_IDLE;
      end else if (state_q == S_EOD && !sh_busy) begin
        state_q <= S_IDLE; // Last byte out, pin passive; no end symbol timed
        inv_crc_q <= 1'b0;
      end
      if (eod_rise && pend_q && is_resp(q_code) && !resp_go) begin
        request_aborted_flag_q <= 1'b1;
        pend_q <= 1'b0;
        command_ready_flag_q <= 1'b1;
      end
      if (cmd_wr) begin
        transmit_command_q <= {avs_writedata[7:4], 1'b0,
                               avs_writedata[2:0]};
        if (wr_code == `VTOC_CODE_CANCEL) begin
          pend_q <= 1'b0;
          command_ready_flag_q <= 1'b1;
        end else if (wr_code == `VTOC_CODE_BRK) begin
          pend_q <= 1'b0; // Break symbol timing lives in the encoder
          command_ready_flag_q <= 1'b1;
        end else if (wr_abort) begin
          request_aborted_flag_q <= 1'b1;
          command_ready_flag_q <= 1'b1;
          if (wr_udf) begin
            underflow_flag_q <= 1'b1;
            inv_crc_q <= 1'b1;
            skip_next_q <= 1'b1;
            state_q <= S_CRC;
          end
        end else begin
          pend_q <= 1'b1;
          command_ready_flag_q <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/vtoc_tx_command_sva.sv
// Checker for the transmit command logic, watching its top ports.
// Assumes the bit cell length is handed on by the bind.
`timescale 1ns/1ps
`default_nettype none
`include "vtoc_defines.vh"
module vtoc_tx_command_chk #(
  parameter CELL = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Register bus
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Bus state and pin
  input wire bus_idle,
  input wire arb_lost,
  input wire bus_output_pin
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire done_w = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire cmd_w = done_w && avs_address[9:2] == `VTOC_IDX_CMD;
  wire [2:0] code = avs_writedata[2:0];
  wire [3:0] len = avs_writedata[7:4];
  reg [7:0] last_q;
  reg lim_off_q;
  integer hi_q;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_q <= 8'h00;
      lim_off_q <= 1'b0;
      hi_q <= 0;
    end else begin
      if (cmd_w)
        last_q <= avs_writedata[7:0] & 8'hf7;
      if (done_w && avs_address[9:2] == `VTOC_IDX_CTRL)
        lim_off_q <= avs_writedata[0];
      hi_q <= bus_output_pin ? hi_q + 1 : 0;
    end
  end
  // Only commands on a quiet idle bus, so a running frame cannot mislead
  sequence s_idle_cmd;
    cmd_w && bus_idle && !bus_output_pin;
  endsequence
  sequence s_quiet;
    !bus_output_pin [*8];
  endsequence
  a_cmd_answer: assert property ($rose(avs_write) &&
    avs_address[9:2] == `VTOC_IDX_CMD |=> !avs_waitrequest)
    else $error("command write not answered after one wait state");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_cmd_readback: assert property (avs_read && !avs_waitrequest &&
    avs_address[9:2] == `VTOC_IDX_CMD |-> avs_readdata == {24'h0, last_q})
    else $error("command register read differs from last write");
  a_sof_start: assert property (s_idle_cmd ##0 !arb_lost &&
    (code == `VTOC_CODE_BODY || code == `VTOC_CODE_LAST)
    |-> ##[1:12] bus_output_pin)
    else $error("body command on idle bus sent nothing");
  a_bad_len_quiet: assert property (s_idle_cmd ##0 code[2] &&
    len > `VTOC_MAX_LEN && !lim_off_q |=> s_quiet)
    else $error("invalid expected length still transmitted");
  a_cancel_quiet: assert property (s_idle_cmd ##0
    code == `VTOC_CODE_CANCEL |=> s_quiet)
    else $error("cancel command drove the pin");
  a_cell_runs: assert property ($fell(bus_output_pin) |->
    hi_q > 0 && hi_q % CELL == 0)
    else $error("active run not a whole number of cells");
endmodule
bind vtoc_tx_command vtoc_tx_command_chk #(.CELL(CELL)) i_chk (
  .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .bus_idle(bus_idle), .arb_lost(arb_lost),
  .bus_output_pin(bus_output_pin));
`default_nettype wire

// ### verif/vtoc_bus_node.sv
// Far bus node: samples the serial pin once per bit cell, mid cell.
// Assumes a frame opens with an active cell, ends after 12 quiet cells.
`timescale 1ns/1ps
`default_nettype none
module vtoc_bus_node #(
  parameter int CELL = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus side
  input wire logic pin,
  input wire logic clr,
  // Captured cells
  output logic [0:31] bits,
  output int cnt,
  output logic done
);
  int ph_q;
  int quiet_q;
  logic on_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst || clr) begin
      on_q <= 1'b0;
      ph_q <= 0;
      cnt <= 0;
      quiet_q <= 0;
      done <= 1'b0;
      bits <= '0;
    end else if (!on_q && !done && pin) begin
      on_q <= 1'b1;
      ph_q <= 1;
    end else if (on_q) begin
      ph_q <= (ph_q == CELL - 1) ? 0 : ph_q + 1;
      if (ph_q == CELL / 2) begin
        if (cnt < 32)
          bits[cnt] <= pin;
        cnt <= cnt + 1;
        quiet_q <= pin ? 0 : quiet_q + 1;
        // Long passive run marks the end of the frame
        if (!pin && quiet_q == 11) begin
          on_q <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the transmit command logic.
// Assumes the bus node model and checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "vtoc_defines.vh"
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  logic bus_idle = 1'b1;
  logic arb_lost = 1'b0;
  logic eod_seen = 1'b0;
  logic crc_ok = 1'b1;
  logic rx_in_response = 1'b0;
  logic [3:0] rx_count = 4'h0;
  wire bus_output_pin;
  logic clr = 1'b0;
  logic [0:31] nbits;
  int ncnt;
  logic ndone;
  int num_errors = 0;
  int num_checks = 0;
  always #5 sys_clk = ~sys_clk;
  vtoc_tx_command #(.CELL(4)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus_idle(bus_idle),
    .arb_lost(arb_lost), .eod_seen(eod_seen), .crc_ok(crc_ok),
    .rx_in_response(rx_in_response), .rx_count(rx_count),
    .bus_output_pin(bus_output_pin));
  vtoc_bus_node #(.CELL(4)) i_node (.sys_clk(sys_clk), .rst(rst),
    .pin(bus_output_pin), .clr(clr), .bits(nbits), .cnt(ncnt),
    .done(ndone));
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Entered just after an edge; holds the request until waitrequest low
  task automatic acc(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k == 50)
      chk(32'h0, 32'h1);
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    acc(1'b1, idx, d, rd);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] m,
                     input logic [7:0] e);
    logic [31:0] rd;
    acc(1'b0, idx, 8'h00, rd);
    chk(rd & {24'hffffff, m}, {24'h0, e});
  endtask
  task automatic arm;
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Synchroniser needs the level held a few cycles
  task automatic eod;
    eod_seen <= 1'b1;
    repeat (4) @(posedge sys_clk);
    eod_seen <= 1'b0;
    repeat (60) @(posedge sys_clk);
  endtask
  task automatic wait_frame;
    int k;
    for (k = 0; k < 400 && ndone !== 1'b1; k++)
      @(posedge sys_clk);
    chk({31'h0, ndone}, 32'h1);
  endtask
  function automatic logic [31:0] getb(input int off);
    logic [31:0] v;
    v = 32'h0;
    for (int k = 0; k < 8; k++)
      v[7 - k] = nbits[off + k];
    return v;
  endfunction
  initial begin
    #100000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    int i;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc(`VTOC_IDX_CMD, 8'hff, 8'h00);
    rdc(`VTOC_IDX_STAT, 8'h07, 8'h01);
    wr(`VTOC_IDX_CMD, 8'h58);
    rdc(`VTOC_IDX_CMD, 8'hff, 8'h50);
    rdc(8'h10, 8'hff, 8'h00);
    wr(`VTOC_IDX_CMD, 8'h01);
    rdc(`VTOC_IDX_STAT, 8'h01, 8'h01);
    arm;
    wr(`VTOC_IDX_DATA, 8'ha5);
    wr(`VTOC_IDX_CMD, 8'hf3);
    wait_frame;
    chk({31'h0, nbits[0]}, 32'h1);
    chk(getb(1), 32'ha5);
    chk(getb(9), 32'h0c);
    chk({31'h0, ncnt > 21 && ncnt <= 29}, 32'h1);
    rdc(`VTOC_IDX_STAT, 8'h07, 8'h01);
    arm;
    wr(`VTOC_IDX_ADDR, 8'hc3);
    bus_idle <= 1'b0;
    rx_count <= 4'h7;
    wr(`VTOC_IDX_CMD, 8'h04);
    eod;
    wait_frame;
    chk(getb(0), 32'hc3);
    rdc(`VTOC_IDX_STAT, 8'h06, 8'h00);
    arm;
    rx_count <= 4'h4;
    wr(`VTOC_IDX_CMD, 8'h34);
    eod;
    chk(ncnt, 0);
    rdc(`VTOC_IDX_STAT, 8'h06, 8'h02);
    wr(`VTOC_IDX_STAT, 8'h00);
    bus_idle <= 1'b1;
    // Lengths 12 to 15 walk the four response codes as well
    for (i = 0; i < 4; i++) begin
      wr(`VTOC_IDX_CMD, {4'hc + i[3:0], 1'b0, 3'h4 + i[2:0]});
      rdc(`VTOC_IDX_STAT, 8'h06, 8'h02);
      wr(`VTOC_IDX_STAT, 8'h00);
    end
    chk(ncnt, 0);
    wr(`VTOC_IDX_CTRL, 8'h01);
    bus_idle <= 1'b0;
    rx_count <= 4'hf;
    wr(`VTOC_IDX_CMD, 8'hf4);
    eod;
    wait_frame;
    chk(getb(0), 32'hc3);
    arm;
    wr(`VTOC_IDX_DATA, 8'hb6);
    wr(`VTOC_IDX_CMD, 8'hf7);
    eod;
    wait_frame;
    chk(getb(0), 32'hb6);
    wr(`VTOC_IDX_CTRL, 8'h00);
    arm;
    rx_in_response <= 1'b1;
    rx_count <= 4'h1;
    wr(`VTOC_IDX_CMD, 8'h14);
    eod;
    rdc(`VTOC_IDX_STAT, 8'h06, 8'h02);
    chk(ncnt, 0);
    rx_in_response <= 1'b0;
    wr(`VTOC_IDX_STAT, 8'h00);
    arm;
    bus_idle <= 1'b1;
    rx_count <= 4'h0;
    wr(`VTOC_IDX_DATA, 8'h81);
    wr(`VTOC_IDX_CMD, 8'h02);
    bus_idle <= 1'b0;
    rx_count <= 4'ha;
    wr(`VTOC_IDX_CMD, 8'h02);
    wait_frame;
    chk(getb(1), 32'h81);
    chk(getb(9), 32'h00);
    rdc(`VTOC_IDX_STAT, 8'h06, 8'h06);
    wr(`VTOC_IDX_STAT, 8'h00);
    arm;
    bus_idle <= 1'b1;
    rx_count <= 4'h0;
    wr(`VTOC_IDX_DATA, 8'h99);
    arb_lost <= 1'b1;
    wr(`VTOC_IDX_CMD, 8'h03);
    rdc(`VTOC_IDX_STAT, 8'h01, 8'h00);
    arb_lost <= 1'b0;
    wait_frame;
    chk(getb(1), 32'h99);
    tally_and_finish;
  end
endmodule
`default_nettype wire
